// ==== src/edp_pkg.sv ====
// edp_pkg: constants, microcode word layout and types for the execution datapath
//
// Overview of operation
// - ALU op finishes in one machine cycle
// - separate address adder forms memory addresses
// - all data formats are two's complement
// - long operands pass as chained 16-bit slices
// - ALU results refresh the four condition bits
// - shifter takes 32 bits, gives 16 bits
// - arithmetic, logical, rotate right up to 31
// - shifter driven by microcode only
// - each step: 4-bit digit times 24 bits
// - sixteen by sixteen multiply takes four steps
// - 48-bit accumulator, low 24 hold multiplier
// - multiplicand comes from both source buses
// - add to top, shift right four, fill
// - nibble shifted to the bottom is next multiplier digit
// - register file is 24 words of 16
// - sixteen user registers, eight microcode-only registers
// - adjacent registers form 32/48-bit operands
// - user registers wrap fifteen to zero
// - bits: carry, positive, zero, negative
// - condition bits hold until next update
package edp_pkg;
   // widths and depths
   localparam int DW        = 16;
   localparam int RF_WORDS  = 24;
   localparam int RF_AW     = 5;
   localparam int SHF_IW    = 32;
   localparam int SHF_AW    = 5;
   localparam int ACC_W     = 48;
   localparam int MCAND_W   = 24;
   localparam int DIGIT_W   = 4;
   localparam int PP_W      = 28;
   // condition bit positions
   localparam int CC_C      = 0;
   localparam int CC_P      = 1;
   localparam int CC_Z      = 2;
   localparam int CC_N      = 3;
   localparam int CC_W      = 4;
   // microcode-only register bank sits above the user bank
   localparam logic [1:0]        MICRO_BANK = 2'h2;
   // multiply step counter
   localparam logic [2:0]        MUL_LAST   = 3'h3;
   localparam logic [2:0]        MUL_CNT_RST = 3'h0;
   // reset values
   localparam logic [CC_W-1:0]   CC_RST     = 4'h0;
   localparam logic [DW-1:0]     DW_RST     = 16'h0000;
   localparam logic [ACC_W-1:0]  ACC_RST    = 48'h000000000000;

   // action of one microcode word
   typedef enum logic [2:0] {K_NOP, K_ALU, K_ADDR, K_SHIFT, K_MLOAD, K_MSTEP} edp_kind_t;
   // alu operations
   typedef enum logic [3:0] {A_ADD, A_ADDC, A_SUB, A_SUBB, A_AND, A_OR, A_XOR, A_NOT,
                             A_PASS} edp_alu_op_t;
   // shifter modes
   typedef enum logic [1:0] {SH_LOG, SH_ARI, SH_ROT} edp_shf_mode_t;
   // r bus and s bus sources
   typedef enum logic [1:0] {RS_RF, RS_IMM, RS_ACCH, RS_ACCM} edp_rsrc_t;
   typedef enum logic [1:0] {SS_RF, SS_IMM, SS_ACCL, SS_ZERO} edp_ssrc_t;

   // decoded microcode word
   typedef struct packed {
      edp_kind_t         kind;
      edp_alu_op_t       alu_op;
      edp_shf_mode_t     shf_mode;
      logic [SHF_AW-1:0] shf_amt;
      logic              user_space;
      logic [RF_AW-1:0]  ra_base;
      logic [1:0]        ra_word;
      logic [RF_AW-1:0]  rb_base;
      logic [1:0]        rb_word;
      edp_rsrc_t         r_src;
      edp_ssrc_t         s_src;
      logic              wr_en;
      logic [RF_AW-1:0]  wd_base;
      logic [1:0]        wd_word;
   } edp_ucode_t;

   // status outputs
   typedef struct packed {
      logic overflow_output;
      logic privilege_fault_output;
      logic mul_done;
   } edp_stat_t;
   localparam edp_stat_t STAT_RST = '{default: 1'b0};
endpackage

// ==== src/edp_shifter.sv ====
// edp_shifter: 32-in, 16-out right barrel shifter
`timescale 1ns/1ps
module edp_shifter
   import edp_pkg::*;
(
   // operand and control
   input  wire logic [SHF_IW-1:0] din,
   input  wire logic [SHF_AW-1:0] amt,
   input  wire edp_shf_mode_t     mode,
   // result
   output logic [DW-1:0]          dout,
   output logic                   cout
);
   logic [2*SHF_IW-1:0] ext_w;   // fill word above the operand
   logic [2*SHF_IW-1:0] sh_w;    // shifted double word
   logic [SHF_IW-1:0]   fill_w;  // fill per mode

   // fill selects zero, sign or the operand itself for a rotate
   assign fill_w = (mode == SH_ROT) ? din :
                   (mode == SH_ARI) ? {SHF_IW{din[SHF_IW-1]}} : {SHF_IW{1'b0}};
   assign ext_w  = {fill_w, din};
   // only right shifts exist
   assign sh_w   = ext_w >> amt;
   assign dout   = sh_w[DW-1:0];
   // last bit out goes to carry; zero when not shifted
   assign cout   = (amt == '0) ? 1'b0 : din[amt - SHF_AW'(1)];
endmodule

// ==== src/edp_datapath.sv ====
// edp_datapath: alu, shifter, multiplier and register file of the execution unit
`timescale 1ns/1ps
module edp_datapath
   import edp_pkg::*;
(
   // clock and reset
   clk,
   sys_rst,
   // microcode word and immediate operand
   uc,
   imm_data,
   // results
   y_r,
   addr_r,
   cond_r,
   acc_r,
   stat_r
);
   // clock and reset
   input  wire logic            clk;
   input  wire logic            sys_rst;
   // microcode word and immediate operand
   input  wire edp_ucode_t      uc;
   input  wire logic [DW-1:0]   imm_data;
   // results
   output logic [DW-1:0]        y_r;
   output logic [DW-1:0]        addr_r;
   output logic [CC_W-1:0]      cond_r;
   output logic [ACC_W-1:0]     acc_r;
   output edp_stat_t            stat_r;

   // register file storage
   logic [DW-1:0]      rf_r [RF_WORDS];     // 24 words
   logic [RF_AW-1:0]   ra_idx;              // port a index
   logic [RF_AW-1:0]   rb_idx;              // port b index
   logic [RF_AW-1:0]   wd_idx;              // write index
   logic [DW-1:0]      rd_a;                // port a data
   logic [DW-1:0]      rd_b;                // port b data
   // operand buses
   logic [DW-1:0]      r_bus;               // r source bus
   logic [DW-1:0]      s_bus;               // s source bus
   // decode
   logic               is_alu;              // alu op
   logic               is_addr;             // address op
   logic               is_shf;              // shift op
   logic               is_mload;            // multiplier load
   logic               is_mstep;            // multiply step
   logic               res_kind;            // op yields a y result
   logic               priv_bad;            // user word names a microcode register
   logic               wr_ok;               // write-back allowed
   // alu
   logic               sub_w;               // subtract family
   logic               chain_w;             // continues a multi-word op
   logic               cin_w;               // adder carry in
   logic [DW-1:0]      bop_w;               // adder second operand
   logic [DW:0]        add_w;               // adder with carry out
   logic               add_ovf;             // signed overflow
   logic [DW-1:0]      alu_res;             // alu result
   logic               alu_c;               // alu carry flag
   logic               alu_arith;           // arithmetic family
   logic [DW-1:0]      addr_sum;            // address adder
   // shifter
   logic [DW-1:0]      sh_out;              // shifter result
   logic               sh_c;                // last bit shifted out
   // multiplier
   logic [MCAND_W-1:0] mcand;               // 24-bit multiplicand
   logic [DIGIT_W-1:0] digit;               // current multiplier digit
   logic [PP_W-1:0]    pp;                  // partial product
   logic [PP_W-1:0]    psum;                // top of accumulator plus product
   logic [ACC_W-1:0]   acc_step;            // accumulator after one step
   logic [2:0]         mul_cnt_r;           // steps since load
   logic [2:0]         mul_cnt_nxt;
   // next values
   logic [DW-1:0]      y_nxt;
   logic [DW-1:0]      addr_nxt;
   logic [CC_W-1:0]    cond_nxt;
   logic [ACC_W-1:0]   acc_nxt;
   edp_stat_t          stat_nxt;

   // index of one word of a multi-word operand; user bank wraps in 16, the
   // microcode bank wraps in its own eight words
   function automatic logic [RF_AW-1:0] rf_index(input logic [RF_AW-1:0] base,
                                                  input logic [1:0]       word);
      logic [3:0] u;
      logic [2:0] m;
      u = base[3:0] + {2'b00, word};
      m = base[2:0] + {1'b0, word};
      if (base[RF_AW-1]) begin
         return {MICRO_BANK, m};
      end
      return {1'b0, u};
   endfunction

   // condition bits from a result; chained slices keep zero only if all were zero
   function automatic logic [CC_W-1:0] mk_cc(input logic [DW-1:0]   res,
                                             input logic            c,
                                             input logic            chain,
                                             input logic [CC_W-1:0] prev);
      logic [CC_W-1:0] f;
      logic            z;
      z       = (res == '0) && (!chain || prev[CC_Z]);
      f       = '0;
      f[CC_C] = c;
      f[CC_N] = res[DW-1];
      f[CC_Z] = z;
      f[CC_P] = !res[DW-1] && !z;
      return f;
   endfunction

   // register indices: the operand names its most significant word
   assign ra_idx = rf_index(uc.ra_base, uc.ra_word);
   assign rb_idx = rf_index(uc.rb_base, uc.rb_word);
   assign wd_idx = rf_index(uc.wd_base, uc.wd_word);
   // two independent read ports
   assign rd_a   = rf_r[ra_idx];
   assign rd_b   = rf_r[rb_idx];

   // op decode
   assign is_alu   = (uc.kind == K_ALU);
   assign is_addr  = (uc.kind == K_ADDR);
   assign is_shf   = (uc.kind == K_SHIFT);
   assign is_mload = (uc.kind == K_MLOAD);
   assign is_mstep = (uc.kind == K_MSTEP);
   assign res_kind = is_alu || is_addr || is_shf;
   // user words write only the lower sixteen registers; reading a higher one from the register file still passes but raises the fault
   assign priv_bad = uc.user_space &&
                     (((uc.r_src == RS_RF) && uc.ra_base[RF_AW-1]) ||
                      ((uc.s_src == SS_RF) && uc.rb_base[RF_AW-1]) ||
                      (uc.wr_en && uc.wd_base[RF_AW-1]));
   assign wr_ok    = uc.wr_en && res_kind && !priv_bad;

   // source bus selection
   assign r_bus = (uc.r_src == RS_RF)   ? rd_a :
                  (uc.r_src == RS_IMM)  ? imm_data :
                  (uc.r_src == RS_ACCH) ? acc_r[ACC_W-1 -: DW] : acc_r[ACC_W-DW-1 -: DW];
   assign s_bus = (uc.s_src == SS_RF)   ? rd_b :
                  (uc.s_src == SS_IMM)  ? imm_data :
                  (uc.s_src == SS_ACCL) ? acc_r[DW-1:0] : DW_RST;

   // two's complement adder; subtract adds the inverse so carry means no borrow
   assign sub_w   = (uc.alu_op == A_SUB) || (uc.alu_op == A_SUBB);
   assign chain_w = (uc.alu_op == A_ADDC) || (uc.alu_op == A_SUBB);
   assign cin_w   = chain_w ? cond_r[CC_C] : sub_w;
   assign bop_w   = sub_w ? ~s_bus : s_bus;
   assign add_w   = {1'b0, r_bus} + {1'b0, bop_w} + {{DW{1'b0}}, cin_w};
   assign add_ovf = (r_bus[DW-1] == bop_w[DW-1]) && (add_w[DW-1] != r_bus[DW-1]);
   // address adder used for operand addresses
   assign addr_sum = r_bus + s_bus;

   // alu function select, one machine cycle
   always_comb begin
      alu_res   = r_bus;
      alu_c     = 1'b0;
      alu_arith = 1'b0;
      unique case (uc.alu_op)
         A_ADD, A_ADDC, A_SUB, A_SUBB: begin
            alu_res   = add_w[DW-1:0];
            alu_c     = add_w[DW];
            alu_arith = 1'b1;
         end
         A_AND:   alu_res = r_bus & s_bus;
         A_OR:    alu_res = r_bus | s_bus;
         A_XOR:   alu_res = r_bus ^ s_bus;
         A_NOT:   alu_res = ~r_bus;
         A_PASS:  alu_res = r_bus;
         // unused op codes pass r unchanged
         default: alu_res = r_bus;
      endcase
   end

   // shifter sees r as the upper half and s as the lower half
   edp_shifter u_shf (
      .din  ({r_bus, s_bus}),
      .amt  (uc.shf_amt),
      .mode (uc.shf_mode),
      .dout (sh_out),
      .cout (sh_c)
   );

   // multiply step: digit from accumulator bottom, multiplicand from both buses
   assign mcand    = {s_bus[MCAND_W-DW-1:0], r_bus};
   assign digit    = acc_r[DIGIT_W-1:0];
   assign pp       = {{MCAND_W{1'b0}}, digit} * {{DIGIT_W{1'b0}}, mcand};
   assign psum     = {{DIGIT_W{1'b0}}, acc_r[ACC_W-1 -: MCAND_W]} + pp;
   assign acc_step = {psum, acc_r[MCAND_W-1:DIGIT_W]};
   // load puts the multiplier in the low 24 bits and clears the rest
   assign acc_nxt  = is_mload ? {{(ACC_W-MCAND_W){1'b0}}, mcand} :
                     is_mstep ? acc_step : acc_r;
   // step counter saturates after the last step
   assign mul_cnt_nxt = is_mload ? MUL_CNT_RST :
                        (is_mstep && mul_cnt_r <= MUL_LAST) ? mul_cnt_r + 3'h1 : mul_cnt_r;

   // result, address and condition selection
   assign y_nxt    = is_alu ? alu_res : is_shf ? sh_out : is_addr ? addr_sum : y_r;
   assign addr_nxt = is_addr ? addr_sum : addr_r;
   assign cond_nxt = is_alu ? mk_cc(alu_res, alu_c, chain_w, cond_r) :
                     is_shf ? mk_cc(sh_out, sh_c, 1'b0, cond_r) : cond_r;
   // status: overflow per arithmetic op, fault and done as pulses
   assign stat_nxt.overflow_output        = (is_alu && alu_arith) ? add_ovf :
                                            stat_r.overflow_output;
   assign stat_nxt.privilege_fault_output = priv_bad;
   assign stat_nxt.mul_done               = is_mstep && (mul_cnt_r == MUL_LAST);

   // register file write port, one process per word
   genvar gi;
   generate
      for (gi = 0; gi < RF_WORDS; gi++) begin : g_rf
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               rf_r[gi] <= DW_RST;
            end else if (wr_ok && (wd_idx == RF_AW'(gi))) begin
               rf_r[gi] <= y_nxt;
            end
         end
      end
   endgenerate

   // result and status registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         y_r    <= DW_RST;
         addr_r <= DW_RST;
         cond_r <= CC_RST;
         stat_r <= STAT_RST;
      end else begin
         y_r    <= y_nxt;
         addr_r <= addr_nxt;
         cond_r <= cond_nxt;
         stat_r <= stat_nxt;
      end
   end

   // multiplier registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         acc_r     <= ACC_RST;
         mul_cnt_r <= MUL_CNT_RST;
      end else begin
         acc_r     <= acc_nxt;
         mul_cnt_r <= mul_cnt_nxt;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence mul_load_s;
      is_mload;
   endsequence
   sequence mul_four_s;
      is_mstep [*4];
   endsequence
   sequence mul_three_s;
      is_mstep [*3];
   endsequence

   alu_one_cycle_a: assert property (
      (is_alu && uc.alu_op == A_ADD) |=> (y_r == $past(add_w[DW-1:0])))
      else $error("alu add result not seen one cycle later");
   addr_calc_a: assert property (
      is_addr |=> (addr_r == $past(addr_sum)) && (cond_r == $past(cond_r)))
      else $error("address op wrong or disturbed condition bits");
   zero_chain_a: assert property (
      (is_alu && chain_w && !cond_r[CC_Z]) |=> !cond_r[CC_Z])
      else $error("chained slice set zero after nonzero slice");
   cond_code_a: assert property (
      (is_alu || is_shf) |=> (cond_r[CC_P] == (!cond_r[CC_N] && !cond_r[CC_Z])))
      else $error("positive bit inconsistent with zero and negative");
   cond_hold_a: assert property (
      !(is_alu || is_shf) |=> $stable(cond_r))
      else $error("condition bits changed without a flag op");
   shift_half_a: assert property (
      (is_shf && uc.shf_mode == SH_LOG && uc.shf_amt == 5'h10) |=> (y_r == $past(r_bus)))
      else $error("logical shift by sixteen did not return upper half");
   mul_four_a: assert property (
      mul_load_s ##1 mul_four_s |=> stat_r.mul_done)
      else $error("multiply not done after four steps");
   mul_early_a: assert property (
      mul_load_s ##1 mul_three_s |=> !stat_r.mul_done)
      else $error("multiply done too early");
   mul_shift_a: assert property (
      is_mstep |=> (acc_r[MCAND_W-DIGIT_W-1:0] == $past(acc_r[MCAND_W-1:DIGIT_W])))
      else $error("accumulator did not shift right four");
   reg_wrap_a: assert property (
      (uc.ra_base == 5'h0F && uc.ra_word == 2'h1) |-> (ra_idx == 5'h00))
      else $error("register fifteen did not wrap to zero");
   // the refused target is looked up by the index of the refused word
   priv_block_a: assert property (
      (uc.user_space && uc.wr_en && uc.wd_base[RF_AW-1] && res_kind)
      |=> stat_r.privilege_fault_output && (rf_r[$past(wd_idx)] == $past(rf_r[wd_idx])))
      else $error("user word reached a microcode register");

   // result bus holds unless the word yields a result
   y_hold_a: assert property (
      !res_kind |=> $stable(y_r))
      else $error("result bus changed without a result op");
   // address register moves only on an address op
   addr_hold_a: assert property (
      !is_addr |=> $stable(addr_r))
      else $error("address register changed without an address op");
   // accumulator moves only on multiplier words
   acc_hold_a: assert property (
      !(is_mload || is_mstep) |=> $stable(acc_r))
      else $error("accumulator changed without a multiplier op");
   // overflow output is refreshed only by arithmetic alu ops
   ovf_hold_a: assert property (
      !(is_alu && alu_arith) |=> $stable(stat_r.overflow_output))
      else $error("overflow output changed without an arithmetic op");
   // fault output stays low for legal words
   fault_pulse_a: assert property (
      !priv_bad |=> !stat_r.privilege_fault_output)
      else $error("privilege fault without a refused word");
   // accepted write-back lands in the addressed word
   rf_write_a: assert property (
      wr_ok |=> (rf_r[$past(wd_idx)] == $past(y_nxt)))
      else $error("register file write did not land");
   // load clears the top and places the multiplier at the bottom
   mul_load_a: assert property (
      is_mload |=> (acc_r == {{(ACC_W-MCAND_W){1'b0}}, $past(s_bus[MCAND_W-DW-1:0]),
                              $past(r_bus)}))
      else $error("multiplier load gave wrong accumulator");
   // top 28 bits after a step are old top plus digit times multiplicand
   mul_top_a: assert property (
      is_mstep |=> (acc_r[ACC_W-1 -: PP_W] == PP_W'($past(acc_r[ACC_W-1 -: MCAND_W])) +
                    PP_W'($past(acc_r[DIGIT_W-1:0])) * PP_W'($past(mcand))))
      else $error("multiply step accumulated a wrong partial product");
   // chained add folds in the stored carry
   carry_chain_a: assert property (
      (is_alu && uc.alu_op == A_ADDC) |=>
      (y_r == $past(r_bus) + $past(s_bus) + DW'($past(cond_r[CC_C]))))
      else $error("chained add ignored the stored carry");
   // subtract carry means no borrow
   borrow_flag_a: assert property (
      (is_alu && uc.alu_op == A_SUB) |=> (cond_r[CC_C] == ($past(r_bus) >= $past(s_bus))))
      else $error("subtract carry does not mean no borrow");
   // zero bit of a single slice follows the result
   zero_flag_a: assert property (
      (is_alu && !chain_w) |=> (cond_r[CC_Z] == (y_r == DW_RST)))
      else $error("zero bit disagrees with result");
   // negative bit follows the result sign
   neg_flag_a: assert property (
      (is_alu || is_shf) |=> (cond_r[CC_N] == y_r[DW-1]))
      else $error("negative bit disagrees with result sign");
   // logic ops leave carry clear
   logic_carry_a: assert property (
      (is_alu && !alu_arith) |=> !cond_r[CC_C])
      else $error("logic op set carry");
   // a shift by zero shifts nothing out
   shift_nocarry_a: assert property (
      (is_shf && uc.shf_amt == 5'h00) |=> !cond_r[CC_C])
      else $error("shift by zero set carry");
endmodule

// ==== dv/edp_seq_model.sv ====
// edp_seq_model: behavioural microcode sequencer that drives the datapath word port
`timescale 1ns/1ps
module edp_seq_model
   import edp_pkg::*;
(
   // clock and reset
   input  wire logic     clk,
   input  wire logic     sys_rst,
   // microcode word and immediate operand
   output edp_ucode_t    uc,
   output logic [DW-1:0] imm_data
);
   // no-action word: kind code zero, nothing written
   localparam edp_ucode_t NOP_W = '0;

   // start idle so nothing is taken while reset is high
   initial begin
      uc = NOP_W;
      imm_data = 16'h0000;
   end

   // present one word just after an edge; the datapath takes it at the next edge
   task automatic issue(input edp_ucode_t w, input logic [DW-1:0] d);
      @(posedge clk);
      uc       <= w;
      imm_data <= d;
   endtask

   // release the port; immediate flips so a stale operand never passes for a fresh one
   task automatic idle();
      @(posedge clk);
      uc       <= NOP_W;
      imm_data <= ~imm_data;
   endtask
endmodule

// ==== dv/edp_datapath_tb.sv ====
// edp_datapath_tb: self-checking bench for the execution datapath
`timescale 1ns/1ps
module edp_datapath_tb;
   import edp_pkg::*;
   // clock, reset and design ports
   logic             clk = 1'b0;
   logic             sys_rst = 1'b1;
   edp_ucode_t       uc;
   logic [DW-1:0]    imm_data;
   logic [DW-1:0]    y_r;
   logic [DW-1:0]    addr_r;
   logic [CC_W-1:0]  cond_r;
   logic [ACC_W-1:0] acc_r;
   edp_stat_t        stat_r;
   // verdict counters
   int               bad_count = 0;
   int               n_tests = 0;
   int               k;
   edp_ucode_t       w;
   logic [31:0]      p;
   // register preload table
   logic [4:0]       g_reg [6] = '{5'h0F, 5'h00, 5'h01, 5'h03, 5'h02, 5'h11};
   logic [15:0]      g_val [6] = '{16'hA5A5, 16'h0001, 16'h5A5A, 16'h0003, 16'h00F1, 16'hBEEF};
   // alu table: op, r operand (immediate), s register, result, condition bits, overflow
   edp_alu_op_t      a_op [10] = '{A_ADD, A_ADDC, A_SUB, A_SUB, A_SUBB, A_AND, A_OR, A_XOR,
                                   A_NOT, A_ADD};
   logic [15:0]      a_r  [10] = '{16'hFFFF, 16'h0000, 16'h0005, 16'h0001, 16'h0005, 16'hA5A5,
                                   16'h0000, 16'h5A5A, 16'h0000, 16'h7FFF};
   logic [4:0]       a_rb [10] = '{5'h00, 5'h00, 5'h03, 5'h03, 5'h00, 5'h01, 5'h00, 5'h01,
                                   5'h00, 5'h00};
   logic [15:0]      a_y  [10] = '{16'h0000, 16'h0002, 16'h0002, 16'hFFFE, 16'h0003, 16'h0000,
                                   16'h0001, 16'h0000, 16'hFFFF, 16'h8000};
   logic [3:0]       a_cc [10] = '{4'h5, 4'h2, 4'h3, 4'h8, 4'h3, 4'h4, 4'h2, 4'h4, 4'h8, 4'h8};
   logic             a_ov [10] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   // shifter table on input 32'h800000F1
   edp_shf_mode_t    s_md [7] = '{SH_LOG, SH_ARI, SH_ROT, SH_LOG, SH_ARI, SH_ROT, SH_LOG};
   logic [4:0]       s_amt[7] = '{5'h14, 5'h14, 5'h14, 5'h00, 5'h1F, 5'h1F, 5'h10};
   logic [15:0]      s_y  [7] = '{16'h0800, 16'hF800, 16'h1800, 16'h00F1, 16'hFFFF, 16'h01E3,
                                  16'h8000};
   // multiply operands
   logic [15:0]      m_a  [2] = '{16'hFFFF, 16'h1234};
   logic [15:0]      m_b  [2] = '{16'hFFFF, 16'h5678};

   // machine cycle clock
   always #12.5 clk = ~clk;

   // design under test
   edp_datapath i_edp_datapath (
      .clk(clk), .sys_rst(sys_rst), .uc(uc), .imm_data(imm_data), .y_r(y_r),
      .addr_r(addr_r), .cond_r(cond_r), .acc_r(acc_r), .stat_r(stat_r)
   );
   // far-side sequencer
   edp_seq_model i_edp_seq_model (
      .clk(clk), .sys_rst(sys_rst), .uc(uc), .imm_data(imm_data)
   );

   // build a word with every unnamed field at zero
   function automatic edp_ucode_t mk(edp_kind_t kd, edp_alu_op_t op, edp_rsrc_t rs,
                                     edp_ssrc_t ss, logic [4:0] ra, logic [4:0] rb,
                                     logic wr, logic [4:0] wd);
      edp_ucode_t m;
      m = '0;
      m.kind = kd;
      m.alu_op = op;
      m.r_src = rs;
      m.s_src = ss;
      m.ra_base = ra;
      m.rb_base = rb;
      m.wr_en = wr;
      m.wd_base = wd;
      return m;
   endfunction

   // compare a value
   task automatic chk_v(input logic [47:0] got, input logic [47:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // compare a flag
   task automatic chk_b(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   // one word, then idle; outputs are settled 1 ns after the taking edge
   task automatic run(input edp_ucode_t wd, input logic [15:0] d);
      i_edp_seq_model.issue(wd, d);
      i_edp_seq_model.idle();
      #1;
   endtask

   // verdict and end of run
   task automatic conclude();
      if (bad_count == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // hang guard
   initial begin
      #(25 * 20000);
      bad_count++;
      conclude();
   end

   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      chk_v({y_r, addr_r, cond_r, stat_r, 9'h000}, 48'h000000000000);
      chk_v(acc_r, 48'h000000000000);
      // preload registers, user and microcode bank
      for (k = 0; k < 6; k++) begin
         run(mk(K_ALU, A_PASS, RS_IMM, SS_ZERO, 0, 0, 1'b1, g_reg[k]), g_val[k]);
      end
      // multi-word operand at R15 wraps to R0 and R1
      for (k = 0; k < 3; k++) begin
         w = mk(K_ALU, A_PASS, RS_RF, SS_ZERO, 5'h0F, 0, 1'b0, 0);
         w.ra_word = 2'(k);
         run(w, 16'h0000);
         chk_v(y_r, g_val[k]);
      end
      run(mk(K_ALU, A_PASS, RS_RF, SS_ZERO, 5'h11, 0, 1'b0, 0), 16'h0000);
      chk_v(y_r, 16'hBEEF);
      run(mk(K_ALU, A_ADD, RS_RF, SS_RF, 5'h00, 5'h01, 1'b0, 0), 16'h0000);
      chk_v(y_r, 16'h5A5B);
      // user word aiming at a microcode register is refused
      w = mk(K_ALU, A_PASS, RS_IMM, SS_ZERO, 0, 0, 1'b1, 5'h10);
      w.user_space = 1'b1;
      run(w, 16'h1111);
      chk_b(stat_r.privilege_fault_output, 1'b1);
      run(mk(K_ALU, A_PASS, RS_RF, SS_ZERO, 5'h10, 0, 1'b0, 0), 16'h0000);
      chk_v(y_r, 16'h0000);
      chk_b(stat_r.privilege_fault_output, 1'b0);
      // alu operations, chained slices and condition bits
      for (k = 0; k < 10; k++) begin
         run(mk(K_ALU, a_op[k], RS_IMM, SS_RF, 0, a_rb[k], 1'b0, 0), a_r[k]);
         chk_v(y_r, a_y[k]);
         chk_v(cond_r, a_cc[k]);
         chk_b(stat_r.overflow_output, a_ov[k]);
      end
      // address calculation leaves condition bits alone
      run(mk(K_ADDR, A_ADD, RS_IMM, SS_RF, 0, 5'h03, 1'b0, 0), 16'h1000);
      chk_v(addr_r, 16'h1003);
      chk_v(cond_r, 4'h8);
      // shifter modes and distances on {r, s}
      for (k = 0; k < 7; k++) begin
         w = mk(K_SHIFT, A_PASS, RS_IMM, SS_RF, 0, 5'h02, 1'b0, 0);
         w.shf_mode = s_md[k];
         w.shf_amt = s_amt[k];
         run(w, 16'h8000);
         chk_v(y_r, s_y[k]);
      end
      // load then four back-to-back steps
      for (k = 0; k < 2; k++) begin
         i_edp_seq_model.issue(mk(K_MLOAD, A_PASS, RS_IMM, SS_ZERO, 0, 0, 1'b0, 0), m_a[k]);
         repeat (4) i_edp_seq_model.issue(mk(K_MSTEP, A_PASS, RS_IMM, SS_ZERO, 0, 0, 1'b0, 0),
                                          m_b[k]);
         i_edp_seq_model.idle();
         #1;
         p = {16'h0000, m_a[k]} * {16'h0000, m_b[k]};
         chk_v(acc_r, {8'h00, p, 8'h00});
         chk_b(stat_r.mul_done, 1'b1);
         @(posedge clk);
         #1;
         chk_b(stat_r.mul_done, 1'b0);
      end
      // a fifth step gives no completion
      run(mk(K_MSTEP, A_PASS, RS_IMM, SS_ZERO, 0, 0, 1'b0, 0), 16'h0000);
      chk_b(stat_r.mul_done, 1'b0);
      conclude();
   end
endmodule
